/* bsis_sampler.sv */
// Bit stream input sampler top: stream capture, observe time, aux bytes
// Operation
// - Sample clock 2 to 32 MHz, optionally 64/128; the code finds sample edges on the 125 MHz clock, so 64/128 MHz is not handled
// - Keep working across 100 ppm clock drift
// - Capture tagged bit at tick, then every 2^k
// - Sample each stream once per 2^k clocks
// - Every power-of-two rate up to clock supported; k is 3 bits, so the code covers clock/1 to clock/128 only
// - Clock discontinuity requires full reset
// - Accept asynchronous alternate tick, one cycle ambiguity
// - Single alternate pulse sets the counter
// - Do not reset counter once set
// - Epoch monitor pulses once per second
// - Aux serial: 115 kbaud, 8N1
// - Receive 2048 aux bytes per second
// - Aux time data may update counter
// - Select 1,2,4,8 or 16 active streams
// - Epoch monitor stretched to about 10 ms
//
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module bsis_sampler
#(
	parameter int EPOCH_CYCLES_P = bsis_pkg::EPOCH_CYCLES
)
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic sample_clock_in,
	input wire logic second_tick_in,
	input wire logic alternate_second_tick_in,
	input wire logic [bsis_pkg::STREAMS-1:0] input_bit_stream_in,
	input wire logic aux_serial_in,
	input wire logic [5:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	output logic [bsis_pkg::STREAMS-1:0] sample_data_out,
	output logic sample_valid_out,
	output logic tick_aligned_out,
	output logic epoch_monitor_out
);
	import bsis_pkg::*;

	localparam int SW = STREAMS + 4;

	// Every stream, sample clock, tick and aux pin passes two flops; data and clock share the same delay
	logic [SW-1:0] sync1_q;
	logic [SW-1:0] sync2_q;
	logic clk_prev_q;
	logic tick_prev_q;
	logic tick_pend_q;
	logic [PHASE_W-1:0] phase_q;
	logic [CTRL_K_W-1:0] k_q;
	logic alt_sel_q;
	logic arm_q;
	logic auxt_en_q;
	logic [31:0] set_sec_q;
	logic [31:0] active_q;
	logic [31:0] clk_hz_q;
	logic [31:0] sec_q;
	logic [31:0] cyc_q;
	logic counter_set_q;
	logic ovf_q;
	logic ferr_q;
	logic [EPOCH_W-1:0] epoch_cnt_q;
	logic [AUX_CW-1:0] aux_cnt_q;
	logic [AUX_AW-1:0] aux_idx_q;
	logic [31:0] aux_time_q;
	logic aux_time_ok_q;
	logic [7:0] rx_byte;
	logic rx_valid;
	logic rx_ferr;
	logic [7:0] mem_rdata;
	logic [5:0] pop;

	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			// Serial line idles high; zero here would fake a start bit
			sync1_q <= {1'b1, {(SW-1){1'b0}}};
			sync2_q <= {1'b1, {(SW-1){1'b0}}};
		end
		else
		begin
			sync1_q <= {aux_serial_in, alternate_second_tick_in,
				second_tick_in, sample_clock_in, input_bit_stream_in};
			sync2_q <= sync1_q;
		end
	end

	wire [STREAMS-1:0] bits_s = sync2_q[STREAMS-1:0];
	wire sclk_s = sync2_q[STREAMS];
	wire tick_s = sync2_q[STREAMS+1];
	wire alt_s = sync2_q[STREAMS+2];
	wire aux_s = sync2_q[STREAMS+3];

	// Edges are found afresh each period, so drift needs no tracking
	wire samp_rise = sclk_s & ~clk_prev_q;
	wire sel_tick = alt_sel_q ? alt_s : tick_s;
	wire tick_rise = sel_tick & ~tick_prev_q;
	// Alternate tick edge is applied at the next sample edge
	wire tick_now = samp_rise & (tick_rise | tick_pend_q);
	wire [PHASE_W-1:0] k_mask = ~(PHASE_ONES << k_q);
	wire take = tick_now | (samp_rise & ((phase_q & k_mask) == '0));
	wire load_arm = tick_now & arm_q;
	wire load_aux = tick_now & ~arm_q & auxt_en_q & aux_time_ok_q;
	wire load_now = load_arm | load_aux;
	wire sec_wrap = samp_rise & ~load_now & (cyc_q == clk_hz_q - 32'h1);
	wire epoch_start = sec_wrap | (samp_rise & load_now);
	wire mask_ok = (pop != 6'h00) && (pop <= 6'(MAX_POP))
		&& ((pop & (pop - 6'h01)) == 6'h00);

	always_comb
	begin
		pop = 6'h00;
		for (int i = 0; i < STREAMS; i++)
			pop = pop + {5'h00, active_q[i]};
	end

	// Bus decode
	wire req = avs_read_in | avs_write_in;
	wire wr_go = avs_write_in & ~avs_waitrequest_out;
	wire [31:0] be_mask = {{8{avs_byteenable_in[3]}},
		{8{avs_byteenable_in[2]}}, {8{avs_byteenable_in[1]}},
		{8{avs_byteenable_in[0]}}};
	wire hit_ctrl = avs_address_in == REG_CTRL;
	wire hit_set = avs_address_in == REG_SET_SEC;
	wire hit_act = avs_address_in == REG_ACTIVE;
	wire hit_st = avs_address_in == REG_STATUS;
	wire hit_sec = avs_address_in == REG_SECONDS;
	wire hit_cyc = avs_address_in == REG_CYCLES;
	wire hit_acnt = avs_address_in == REG_AUX_COUNT;
	wire hit_aidx = avs_address_in == REG_AUX_INDEX;
	wire hit_adat = avs_address_in == REG_AUX_DATA;
	wire hit_hz = avs_address_in == REG_CLK_HZ;
	wire [31:0] wmerge_set = (set_sec_q & ~be_mask)
		| (avs_writedata_in & be_mask);
	wire [31:0] wmerge_act = (active_q & ~be_mask)
		| (avs_writedata_in & be_mask);
	wire [31:0] wmerge_hz = (clk_hz_q & ~be_mask)
		| (avs_writedata_in & be_mask);
	wire ctrl_we = wr_go & hit_ctrl & avs_byteenable_in[0];
	wire st_we = wr_go & hit_st & avs_byteenable_in[0];
	wire [31:0] ctrl_rd = {26'h0, auxt_en_q, arm_q, alt_sel_q, k_q};
	wire [31:0] st_rd = {27'h0, aux_time_ok_q, ferr_q, ovf_q, mask_ok,
		counter_set_q};
	wire [31:0] rd_mux =
		hit_ctrl ? ctrl_rd :
		hit_set ? set_sec_q :
		hit_act ? active_q :
		hit_st ? st_rd :
		hit_sec ? sec_q :
		hit_cyc ? cyc_q :
		hit_acnt ? {20'h0, aux_cnt_q} :
		hit_aidx ? {21'h0, aux_idx_q} :
		hit_adat ? {24'h0, mem_rdata} :
		hit_hz ? clk_hz_q : 32'h0;

	// Answer one cycle after the request is seen, released after taken
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out <= 32'h0;
		end
		else
		begin
			avs_waitrequest_out <= ~(req & avs_waitrequest_out);
			if (avs_read_in & avs_waitrequest_out)
				avs_readdata_out <= rd_mux;
		end
	end

	// Configuration registers
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			k_q <= K_RESET;
			alt_sel_q <= 1'b0;
			auxt_en_q <= 1'b0;
			set_sec_q <= 32'h0;
			active_q <= ACTIVE_RESET;
			clk_hz_q <= CLK_HZ_RESET;
			aux_idx_q <= '0;
		end
		else
		begin
			if (ctrl_we)
			begin
				k_q <= avs_writedata_in[CTRL_K_LSB +: CTRL_K_W];
				alt_sel_q <= avs_writedata_in[CTRL_ALT_BIT];
				auxt_en_q <= avs_writedata_in[CTRL_AUXT_BIT];
			end
			if (wr_go & hit_set)
				set_sec_q <= wmerge_set;
			if (wr_go & hit_act)
				active_q <= wmerge_act;
			if (wr_go & hit_hz)
				clk_hz_q <= wmerge_hz;
			if (wr_go & hit_aidx)
				aux_idx_q <= avs_writedata_in[AUX_AW-1:0];
		end
	end

	// Edge history and sample phase
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			clk_prev_q <= 1'b0;
			tick_prev_q <= 1'b0;
			tick_pend_q <= 1'b0;
			phase_q <= '0;
		end
		else
		begin
			clk_prev_q <= sclk_s;
			tick_prev_q <= sel_tick;
			// A tick used at this sample edge must not stay pending
			tick_pend_q <= (tick_rise | tick_pend_q) & ~samp_rise;
			if (tick_now)
				phase_q <= {{(PHASE_W-1){1'b0}}, 1'b1};
			else if (samp_rise)
				phase_q <= phase_q + 1'b1;
		end
	end

	// Captured streams; inactive lines are forced to zero
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			sample_data_out <= '0;
			sample_valid_out <= 1'b0;
			tick_aligned_out <= 1'b0;
		end
		else
		begin
			sample_valid_out <= take;
			if (take)
			begin
				sample_data_out <= bits_s & active_q;
				tick_aligned_out <= tick_now;
			end
		end
	end

	// Observe time: loaded at a tick when armed or from the aux time bytes, then counts sample edges
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			sec_q <= 32'h0;
			cyc_q <= 32'h0;
			arm_q <= 1'b0;
			counter_set_q <= 1'b0;
		end
		else
		begin
			if (load_arm)
				arm_q <= 1'b0;
			else if (ctrl_we)
				arm_q <= avs_writedata_in[CTRL_ARM_BIT];
			if (load_now)
			begin
				sec_q <= load_arm ? set_sec_q : aux_time_q;
				cyc_q <= 32'h0;
				counter_set_q <= 1'b1;
			end
			else if (sec_wrap)
			begin
				sec_q <= sec_q + 32'h1;
				cyc_q <= 32'h0;
			end
			else if (samp_rise)
				cyc_q <= cyc_q + 32'h1;
		end
	end

	// Stretched once-per-second monitor
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			epoch_cnt_q <= '0;
			epoch_monitor_out <= 1'b0;
		end
		else
		begin
			if (epoch_start)
				epoch_cnt_q <= EPOCH_W'(EPOCH_CYCLES_P - 1);
			else if (epoch_cnt_q != '0)
				epoch_cnt_q <= epoch_cnt_q - 1'b1;
			epoch_monitor_out <= epoch_start
				| (epoch_cnt_q > EPOCH_W'(1));
		end
	end

	// Aux burst bookkeeping; count restarts on each selected tick
	wire aux_room = aux_cnt_q < AUX_CW'(AUX_DEPTH);
	wire [AUX_CW-1:0] aux_base = tick_now ? '0 : aux_cnt_q;
	wire aux_wr = rx_valid & (tick_now | aux_room);
	wire aux_tb = aux_base < AUX_CW'(AUX_TIME_BYTES);
	wire aux_tlast = aux_base == AUX_CW'(AUX_TIME_BYTES - 1);

	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			aux_cnt_q <= '0;
			aux_time_q <= 32'h0;
			aux_time_ok_q <= 1'b0;
			ovf_q <= 1'b0;
			ferr_q <= 1'b0;
		end
		else
		begin
			if (aux_wr)
				aux_cnt_q <= aux_base + 1'b1;
			else if (tick_now)
				aux_cnt_q <= '0;
			if (aux_wr & aux_tb)
				aux_time_q <= {aux_time_q[23:0], rx_byte};
			if (aux_wr & aux_tlast)
				aux_time_ok_q <= 1'b1;
			else if (load_aux | (tick_now & ~aux_wr))
				aux_time_ok_q <= 1'b0;
			// Hardware set wins over a same-cycle software clear
			ovf_q <= (rx_valid & ~tick_now & ~aux_room)
				| (ovf_q & ~(st_we & avs_writedata_in[ST_OVF_BIT]));
			ferr_q <= rx_ferr
				| (ferr_q & ~(st_we & avs_writedata_in[ST_FERR_BIT]));
		end
	end

	bsis_uart_rx u_rx
	(
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.rx_in(aux_s),
		.byte_out(rx_byte),
		.valid_out(rx_valid),
		.frame_err_out(rx_ferr)
	);

	bsis_byte_mem u_mem
	(
		.clock_in(clock_in),
		.wr_en_in(aux_wr),
		.wr_addr_in(aux_base[AUX_AW-1:0]),
		.wr_data_in(rx_byte),
		.rd_addr_in(aux_idx_q),
		.rd_data_out(mem_rdata)
	);
endmodule
`default_nettype wire

/* bsis_pkg.sv */
// Constants shared by the bit stream input sampler files
package bsis_pkg;
	// Register byte offsets
	localparam logic [5:0] REG_CTRL = 6'h00;
	localparam logic [5:0] REG_SET_SEC = 6'h04;
	localparam logic [5:0] REG_ACTIVE = 6'h08;
	localparam logic [5:0] REG_STATUS = 6'h0C;
	localparam logic [5:0] REG_SECONDS = 6'h10;
	localparam logic [5:0] REG_CYCLES = 6'h14;
	localparam logic [5:0] REG_AUX_COUNT = 6'h18;
	localparam logic [5:0] REG_AUX_INDEX = 6'h1C;
	localparam logic [5:0] REG_AUX_DATA = 6'h20;
	localparam logic [5:0] REG_CLK_HZ = 6'h24;
	// Control fields
	localparam int CTRL_K_LSB = 0;
	localparam int CTRL_K_W = 3;
	localparam int CTRL_ALT_BIT = 3;
	localparam int CTRL_ARM_BIT = 4;
	localparam int CTRL_AUXT_BIT = 5;
	// Status fields
	localparam int ST_SET_BIT = 0;
	localparam int ST_MASK_OK_BIT = 1;
	localparam int ST_OVF_BIT = 2;
	localparam int ST_FERR_BIT = 3;
	localparam int ST_AUXT_BIT = 4;
	// Reset values
	localparam logic [2:0] K_RESET = 3'h0;
	localparam logic [31:0] ACTIVE_RESET = 32'h0000FFFF;
	localparam logic [31:0] CLK_HZ_RESET = 32'h01E84800;
	// Stream geometry
	localparam int STREAMS = 32;
	localparam int PHASE_W = 7;
	localparam logic [PHASE_W-1:0] PHASE_ONES = 7'h7F;
	localparam int MAX_POP = 16;
	// Aux serial burst store
	localparam int AUX_DEPTH = 2048;
	localparam int AUX_AW = 11;
	localparam int AUX_CW = 12;
	localparam int AUX_TIME_BYTES = 4;
	// Timing
	localparam longint CLOCK_HZ = 125000000;
	localparam longint AUX_BAUD = 115000;
	localparam int AUX_BIT_CYCLES = int'(CLOCK_HZ / AUX_BAUD);
	localparam longint EPOCH_MS = 10;
	localparam int EPOCH_CYCLES = int'(CLOCK_HZ * EPOCH_MS / 1000);
	localparam int EPOCH_W = 24;
endpackage

/* bsis_byte_mem.sv */
// Burst byte store with registered read data
`timescale 1ns/10ps
`default_nettype none
module bsis_byte_mem
(
	input wire logic clock_in,
	input wire logic wr_en_in,
	input wire logic [bsis_pkg::AUX_AW-1:0] wr_addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic [bsis_pkg::AUX_AW-1:0] rd_addr_in,
	output logic [7:0] rd_data_out
);
	import bsis_pkg::*;

	logic [7:0] mem [0:AUX_DEPTH-1];

	always_ff @(posedge clock_in)
	begin
		if (wr_en_in)
			mem[wr_addr_in] <= wr_data_in;
		rd_data_out <= mem[rd_addr_in];
	end
endmodule
`default_nettype wire

/* bsis_uart_rx.sv */
// Asynchronous serial byte receiver, 8 data bits, one stop, no parity
`timescale 1ns/10ps
`default_nettype none
module bsis_uart_rx
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic rx_in,
	output logic [7:0] byte_out,
	output logic valid_out,
	output logic frame_err_out
);
	import bsis_pkg::*;

	typedef enum logic [1:0] {IDLE, START, DATA, STOP} bsis_rx_state_type;

	localparam logic [10:0] BIT_LAST = 11'(AUX_BIT_CYCLES - 1);
	localparam logic [10:0] HALF_LAST = 11'(AUX_BIT_CYCLES / 2 - 1);

	bsis_rx_state_type state_q;
	logic [10:0] cnt_q;
	logic [2:0] bit_q;
	logic [7:0] shift_q;
	wire cnt_done = (cnt_q == 11'h000);

	// Bits are taken at mid-bit so small baud mismatch is tolerated
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_q <= IDLE;
			cnt_q <= 11'h000;
			bit_q <= 3'h0;
			shift_q <= 8'h00;
			byte_out <= 8'h00;
			valid_out <= 1'b0;
			frame_err_out <= 1'b0;
		end
		else
		begin
			valid_out <= 1'b0;
			frame_err_out <= 1'b0;
			if (!cnt_done)
				cnt_q <= cnt_q - 11'h001;
			case (state_q)
				IDLE:
					if (!rx_in)
					begin
						state_q <= START;
						cnt_q <= HALF_LAST;
					end
				START:
					if (cnt_done)
					begin
						state_q <= rx_in ? IDLE : DATA;
						cnt_q <= BIT_LAST;
						bit_q <= 3'h0;
					end
				DATA:
					if (cnt_done)
					begin
						shift_q <= {rx_in, shift_q[7:1]};
						bit_q <= bit_q + 3'h1;
						cnt_q <= BIT_LAST;
						if (bit_q == 3'h7)
							state_q <= STOP;
					end
				STOP:
					if (cnt_done)
					begin
						state_q <= IDLE;
						byte_out <= shift_q;
						valid_out <= rx_in;
						frame_err_out <= !rx_in;
					end
				default:
					state_q <= IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

/* bsis_sampler_assertions.sv */
// Port timing checker for the bit stream input sampler
`timescale 1ns/10ps
`default_nettype none
module bsis_sampler_assertions
#(
	parameter int EPOCH_CYCLES_P = 20
)
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic avs_waitrequest_out,
	input wire logic [bsis_pkg::STREAMS-1:0] sample_data_out,
	input wire logic sample_valid_out,
	input wire logic tick_aligned_out,
	input wire logic epoch_monitor_out
);
	import bsis_pkg::*;
	logic [23:0] epoch_len_q;
	logic [23:0] epoch_len_d;
	// Counted in helper logic, the pulse is far too long for a repetition
	assign epoch_len_d = epoch_monitor_out ? epoch_len_q + 24'h1 : 24'h0;
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			epoch_len_q <= 24'h0;
		else
			epoch_len_q <= epoch_len_d;
	end
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	a_bus_answer: assert property ((avs_read_in || avs_write_in) &&
		avs_waitrequest_out |=> !avs_waitrequest_out) else $error("bus answer late");
	a_bus_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("bus answer held too long");
	a_bus_quiet: assert property (avs_waitrequest_out && !avs_read_in &&
		!avs_write_in |=> avs_waitrequest_out) else $error("answer without request");
	a_sample_gap: assert property (sample_valid_out |=> !sample_valid_out[*8])
		else $error("samples too close");
	a_data_hold: assert property (!sample_valid_out |-> $stable(sample_data_out))
		else $error("data moved between samples");
	a_tag_hold: assert property (!sample_valid_out |-> $stable(tick_aligned_out))
		else $error("tag moved between samples");
	a_epoch_wide: assert property ($rose(epoch_monitor_out) |=>
		epoch_monitor_out[*8]) else $error("monitor pulse too short");
	a_epoch_bound: assert property (epoch_len_q <= 24'(EPOCH_CYCLES_P))
		else $error("monitor pulse too long");
	cover property (sample_valid_out && tick_aligned_out);
	cover property ($rose(epoch_monitor_out));
	cover property (avs_write_in && !avs_waitrequest_out);
endmodule
bind bsis_sampler bsis_sampler_assertions #(.EPOCH_CYCLES_P(EPOCH_CYCLES_P))
	i_chk (.clock_in(clock_in), .rst_n_in(rst_n_in), .avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
	.sample_data_out(sample_data_out), .sample_valid_out(sample_valid_out),
	.tick_aligned_out(tick_aligned_out), .epoch_monitor_out(epoch_monitor_out));
`default_nettype wire

/* bsis_das_model.sv */
// Acquisition system model: sample clock, ticks, streams, serial bytes
`timescale 1ns/10ps
`default_nettype none
module bsis_das_model
#(
	parameter int TICK_P = 64
)
(
	output logic sample_clock_out,
	output logic second_tick_out,
	output logic alternate_second_tick_out,
	output logic [31:0] input_bit_stream_out,
	output logic aux_serial_out
);
	bit tick_en = 1'b1;
	int cnt = 0;
	initial
	begin
		alternate_second_tick_out = 1'b0;
		aux_serial_out = 1'b1;
	end
	// Runs free, as the samplers behind it always do
	initial
	begin
		sample_clock_out = 1'b0;
		forever
			#62.5 sample_clock_out = ~sample_clock_out;
	end
	initial
	begin
		second_tick_out = 1'b0;
		input_bit_stream_out = 32'h0;
		forever
		begin
			@(posedge sample_clock_out);
			cnt = (cnt + 1) % TICK_P;
			// Tick and tagged bit leave on the same edge, one period wide
			second_tick_out <= tick_en && cnt == 0;
			input_bit_stream_out <= {4{8'(cnt)}};
		end
	end
	task automatic alt_pulse();
		#37;
		alternate_second_tick_out = 1'b1;
		#300;
		alternate_second_tick_out = 1'b0;
	endtask
	task automatic send_byte(input logic [7:0] b);
		for (int i = 0; i < 10; i++)
		begin
			aux_serial_out = i == 0 ? 1'b0 : i == 9 ? 1'b1 : b[i - 1];
			#8696;
		end
	endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the bit stream input sampler
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import bsis_pkg::*;
	localparam int TP = 64;
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic sclk, tick, alt, aux, wait_o, valid, tal, epoch;
	logic [31:0] bs, rdata, sdata, q;
	logic [5:0] addr = 6'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] mask = ACTIVE_RESET;
	logic [31:0] mtab [4] = '{32'h0, 32'hFFFF0000, 32'h00000001, 32'hFFFFFFFF};
	logic [15:0] rnd = 16'hB7F4;
	logic [15:0] sec;
	logic [7:0] b [4];
	int errors = 0;
	int tests_run = 0;
	int k = 0;
	int idx = 0;
	bit sync = 1'b0;
	bit mon = 1'b0;
	always #4 clock_in = ~clock_in;
	bsis_sampler #(.EPOCH_CYCLES_P(20)) i_bsis_sampler (.clock_in(clock_in),
		.rst_n_in(rst_n_in), .sample_clock_in(sclk), .second_tick_in(tick),
		.alternate_second_tick_in(alt), .input_bit_stream_in(bs),
		.aux_serial_in(aux), .avs_address_in(addr), .avs_read_in(rd),
		.avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wait_o),
		.sample_data_out(sdata), .sample_valid_out(valid),
		.tick_aligned_out(tal), .epoch_monitor_out(epoch));
	bsis_das_model #(.TICK_P(TP)) u_das (.sample_clock_out(sclk),
		.second_tick_out(tick), .alternate_second_tick_out(alt),
		.input_bit_stream_out(bs), .aux_serial_out(aux));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic mask_legal(input logic [31:0] m);
		int c = $countones(m);
		return c == 1 || c == 2 || c == 4 || c == 8 || c == 16;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clock_in);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		do
		begin
			@(posedge clock_in);
			n++;
		end
		while (wait_o !== 1'b0 && n < 50);
		check(32'(n < 50), 32'h1);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(q, exp);
	endtask
	task automatic wait_ticks(input int t);
		int n = 0;
		while (t > 0 && n < 5000)
		begin
			@(posedge clock_in);
			n++;
			if (valid === 1'b1 && tal === 1'b1)
				t--;
		end
		check(32'(t), 32'h0);
	endtask
	// Expected sample follows the model's count since the tick
	always @(posedge clock_in)
	begin
		if (valid === 1'b1 && mon && sync)
		begin
			idx = (idx + (1 << k)) % TP;
			check(32'(tal), 32'(idx == 0));
			check(sdata, {4{8'(idx)}} & mask);
		end
		else if (valid === 1'b1 && mon && tal === 1'b1)
		begin
			sync = 1'b1;
			idx = 0;
		end
		else if (!mon)
			sync = 1'b0;
	end
	initial
	begin
		repeat (90000) @(posedge clock_in);
		errors++;
		results();
	end
	initial
	begin
		repeat (4) @(posedge clock_in);
		rst_n_in <= 1'b1;
		rdchk(REG_CTRL, 32'h0);
		rdchk(REG_ACTIVE, ACTIVE_RESET);
		rdchk(REG_CLK_HZ, CLK_HZ_RESET);
		rdchk(6'h3C, 32'h0);
		bus(1'b1, REG_CLK_HZ, 32'(TP));
		rnd = lfsr(rnd);
		mtab[0] = {rnd, lfsr(rnd)};
		for (int i = 0; i < 4; i++)
		begin
			mon = 1'b0;
			k = i % 3;
			mask = mtab[i];
			bus(1'b1, REG_ACTIVE, mask);
			bus(1'b1, REG_CTRL, 32'(k));
			rdchk(REG_CTRL, 32'(k));
			bus(1'b0, REG_STATUS, 32'h0);
			check(32'(q[ST_MASK_OK_BIT]), 32'(mask_legal(mask)));
			mon = 1'b1;
			wait_ticks(3);
		end
		sec = lfsr(rnd);
		bus(1'b1, REG_SET_SEC, {16'h0, sec});
		bus(1'b1, REG_CTRL, 32'h10);
		wait_ticks(1);
		check(32'(epoch), 32'h1);
		rdchk(REG_SECONDS, {16'h0, sec});
		rdchk(REG_CTRL, 32'h0);
		wait_ticks(2);
		rdchk(REG_SECONDS, {16'h0, sec} + 32'h2);
		mon = 1'b0;
		rnd = lfsr(sec);
		bus(1'b1, REG_SET_SEC, {16'h0, rnd});
		bus(1'b1, REG_CTRL, 32'h18);
		u_das.alt_pulse();
		rdchk(REG_SECONDS, {16'h0, rnd});
		bus(1'b1, REG_CTRL, 32'h0);
		wait_ticks(1);
		// Ticks stop so the byte count is not cleared mid burst
		u_das.tick_en = 1'b0;
		b[0] = rnd[7:0];
		b[1] = rnd[15:8];
		b[2] = sec[7:0];
		b[3] = sec[15:8];
		for (int i = 0; i < 4; i++)
			u_das.send_byte(b[i]);
		rdchk(REG_AUX_COUNT, 32'h4);
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, REG_AUX_INDEX, 32'(i));
			repeat (2) @(posedge clock_in);
			rdchk(REG_AUX_DATA, {24'h0, b[i]});
		end
		bus(1'b0, REG_STATUS, 32'h0);
		check(32'(q[ST_FERR_BIT]), 32'h0);
		check(32'(q[ST_AUXT_BIT]), 32'h1);
		// Time bytes of the burst set the counter on the next tick
		bus(1'b1, REG_CTRL, 32'h20);
		u_das.tick_en = 1'b1;
		wait_ticks(1);
		rdchk(REG_SECONDS, {b[0], b[1], b[2], b[3]});
		rst_n_in <= 1'b0;
		repeat (4) @(posedge clock_in);
		rst_n_in <= 1'b1;
		rdchk(REG_SECONDS, 32'h0);
		results();
	end
endmodule
`default_nettype wire
